/* File: trim_pkg.sv */
package trim_pkg;

  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 16;
  localparam int TIMING_W = 8;
  localparam int OFFSET_W = 12;
  localparam int TRIM_COUNT = 9;
  localparam int IDX_W    = 4;
  localparam int CTRL_W   = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] A_DUAL_TIMING_OFS   = 12'h310;
  localparam logic [ADDR_W-1:0] B_DUAL_TIMING_OFS   = 12'h313;
  localparam logic [ADDR_W-1:0] A_SGL_INA_TIM_OFS   = 12'h314;
  localparam logic [ADDR_W-1:0] B_SGL_INA_TIM_OFS   = 12'h315;
  localparam logic [ADDR_W-1:0] A_SGL_INB_TIM_OFS   = 12'h31A;
  localparam logic [ADDR_W-1:0] B_SGL_INB_TIM_OFS   = 12'h31B;
  localparam logic [ADDR_W-1:0] A_DUAL_INA_OFF_OFS  = 12'h344;
  localparam logic [ADDR_W-1:0] A_DUAL_INB_OFF_OFS  = 12'h346;
  localparam logic [ADDR_W-1:0] A_SGL_INA_OFF_OFS   = 12'h348;
  localparam logic [ADDR_W-1:0] CTRL_OFS            = 12'h350;
  localparam logic [ADDR_W-1:0] STATUS_OFS          = 12'h351;

  // Storage index of each trim
  localparam logic [IDX_W-1:0] A_DUAL_TIMING_IDX  = 4'h0;
  localparam logic [IDX_W-1:0] B_DUAL_TIMING_IDX  = 4'h1;
  localparam logic [IDX_W-1:0] A_SGL_INA_TIM_IDX  = 4'h2;
  localparam logic [IDX_W-1:0] B_SGL_INA_TIM_IDX  = 4'h3;
  localparam logic [IDX_W-1:0] A_SGL_INB_TIM_IDX  = 4'h4;
  localparam logic [IDX_W-1:0] B_SGL_INB_TIM_IDX  = 4'h5;
  localparam logic [IDX_W-1:0] A_DUAL_INA_OFF_IDX = 4'h6;
  localparam logic [IDX_W-1:0] A_DUAL_INB_OFF_IDX = 4'h7;
  localparam logic [IDX_W-1:0] A_SGL_INA_OFF_IDX  = 4'h8;

  // Control and status fields
  localparam int CTRL_SINGLE_BIT  = 0;
  localparam int CTRL_FGCAL_BIT   = 1;
  localparam int CTRL_INSEL_BIT   = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam int STATUS_LOADING_BIT = 0;
  localparam logic [DATA_W-1:0] TRIM_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] TIMING_MASK = 16'h00FF;
  localparam logic [DATA_W-1:0] OFFSET_MASK = 16'hFFFF;

  function automatic logic [DATA_W-1:0] trim_mask(input logic [IDX_W-1:0] idx);
    return (idx >= A_DUAL_INA_OFF_IDX) ? OFFSET_MASK : TIMING_MASK;
  endfunction

  // Returns {hit, index}
  function automatic logic [IDX_W:0] trim_lookup(input logic [ADDR_W-1:0] addr);
    case (addr)
      A_DUAL_TIMING_OFS:  return {1'b1, A_DUAL_TIMING_IDX};
      B_DUAL_TIMING_OFS:  return {1'b1, B_DUAL_TIMING_IDX};
      A_SGL_INA_TIM_OFS:  return {1'b1, A_SGL_INA_TIM_IDX};
      B_SGL_INA_TIM_OFS:  return {1'b1, B_SGL_INA_TIM_IDX};
      A_SGL_INB_TIM_OFS:  return {1'b1, A_SGL_INB_TIM_IDX};
      B_SGL_INB_TIM_OFS:  return {1'b1, B_SGL_INB_TIM_IDX};
      A_DUAL_INA_OFF_OFS: return {1'b1, A_DUAL_INA_OFF_IDX};
      A_DUAL_INB_OFF_OFS: return {1'b1, A_DUAL_INB_OFF_IDX};
      A_SGL_INA_OFF_OFS:  return {1'b1, A_SGL_INA_OFF_IDX};
      default:            return 5'h00;
    endcase
  endfunction

endpackage

/* File: fuse_loader.sv */
`timescale 1ns/10ps
module fuse_loader (
  input  wire logic                          clk,       // System clock
  input  wire logic                          rst,       // Synchronous reset
  output      logic [trim_pkg::IDX_W-1:0]    fuse_addr, // Fuse word address
  input  wire logic [trim_pkg::DATA_W-1:0]   fuse_data, // Fuse word, one cycle after address
  output      logic                          load_we,   // Load strobe
  output      logic [trim_pkg::IDX_W-1:0]    load_idx,  // Trim being loaded
  output      logic [trim_pkg::DATA_W-1:0]   load_data, // Fuse value to load
  output      logic                          loading    // Fuse copy in progress
);
  import trim_pkg::*;

  typedef enum logic [1:0] {phase_fetch, phase_drain, phase_idle} phase_type;

  typedef struct packed {
    phase_type        phase;
    logic [IDX_W-1:0] count;
    logic             pend;
    logic [IDX_W-1:0] pidx;
  } loader_state_type;

  loader_state_type cur;
  loader_state_type next_cur;

  always_comb
  begin
    next_cur = cur;
    unique case (cur.phase)
      phase_fetch:
      begin
        next_cur.pend = 1'b1;
        next_cur.pidx = cur.count;
        if (cur.count == IDX_W'(TRIM_COUNT - 1))
          next_cur.phase = phase_drain;
        else
          next_cur.count = cur.count + 4'h1;
      end
      phase_drain:
      begin
        next_cur.pend  = 1'b0;
        next_cur.phase = phase_idle;
      end
      phase_idle:
        next_cur.pend = 1'b0;
    endcase
    if (rst)
      next_cur = '{phase_fetch, 4'h0, 1'b0, 4'h0};
  end

  always_ff @(posedge clk)
    cur <= next_cur;

  assign fuse_addr = cur.count;
  assign load_we   = cur.pend;
  assign load_idx  = cur.pidx;
  assign load_data = fuse_data;
  assign loading   = (cur.phase != phase_idle);

endmodule

/* File: trim_route.sv */
`timescale 1ns/10ps
module trim_route (
  input  wire logic                                               clk,            // System clock
  input  wire logic                                               rst,            // Synchronous reset
  input  wire logic [trim_pkg::TRIM_COUNT-1:0][trim_pkg::DATA_W-1:0] trim,         // Stored trims
  input  wire logic [trim_pkg::CTRL_W-1:0]                        ctrl,           // Mode controls
  output      logic [trim_pkg::TIMING_W-1:0]                      a_timing_trim,  // A core timing
  output      logic [trim_pkg::TIMING_W-1:0]                      b_timing_trim,  // B core timing
  output      logic [trim_pkg::OFFSET_W-1:0]                      a_offset_trim,  // A core offset
  output      logic                                               a_offset_apply, // A offset valid
  output      logic                                               trim_apply      // Timing trims valid
);
  import trim_pkg::*;

  typedef struct packed {
    logic [TIMING_W-1:0] a_t;
    logic [TIMING_W-1:0] b_t;
    logic [OFFSET_W-1:0] a_o;
    logic                a_ok;
    logic                t_ok;
  } route_state_type;

  route_state_type cur;
  route_state_type next_cur;
  logic            single;
  logic            insel;

  always_comb
  begin
    single   = ctrl[CTRL_SINGLE_BIT];
    insel    = ctrl[CTRL_INSEL_BIT];
    next_cur = '0;
    if (ctrl[CTRL_FGCAL_BIT])
    begin
      next_cur.t_ok = 1'b1;
      if (!single)
      begin
        next_cur.a_t  = trim[A_DUAL_TIMING_IDX][TIMING_W-1:0];
        next_cur.b_t  = trim[B_DUAL_TIMING_IDX][TIMING_W-1:0];
        next_cur.a_o  = insel ? trim[A_DUAL_INB_OFF_IDX][OFFSET_W-1:0]
                              : trim[A_DUAL_INA_OFF_IDX][OFFSET_W-1:0];
        next_cur.a_ok = 1'b1;
      end
      else if (!insel)
      begin
        next_cur.a_t  = trim[A_SGL_INA_TIM_IDX][TIMING_W-1:0];
        next_cur.b_t  = trim[B_SGL_INA_TIM_IDX][TIMING_W-1:0];
        next_cur.a_o  = trim[A_SGL_INA_OFF_IDX][OFFSET_W-1:0];
        next_cur.a_ok = 1'b1;
      end
      else
      begin
        next_cur.a_t = trim[A_SGL_INB_TIM_IDX][TIMING_W-1:0];
        next_cur.b_t = trim[B_SGL_INB_TIM_IDX][TIMING_W-1:0];
      end
    end
    if (rst)
      next_cur = '0;
  end

  always_ff @(posedge clk)
    cur <= next_cur;

  assign a_timing_trim  = cur.a_t;
  assign b_timing_trim  = cur.b_t;
  assign a_offset_trim  = cur.a_o;
  assign a_offset_apply = cur.a_ok;
  assign trim_apply     = cur.t_ok;

endmodule

/* File: core_trim_register_bank.sv */
// Implementation choice: strobed register access.
`timescale 1ns/10ps
// What this block does
// - Holds an eight-bit timing trim for the B core in dual channel mode with calibration on.
// - Holds an eight-bit timing trim for the A core in single channel mode on the first input.
// - Holds an eight-bit timing trim for the B core in single channel mode on the first input.
// - Holds an eight-bit timing trim for the A core in single channel mode on the second input.
// - Holds an eight-bit timing trim for the B core in single channel mode on the second input.
// - Applies a twelve-bit offset to the A core sampling the first input in dual channel mode.
// - Applies a separate twelve-bit offset to the A core sampling the second input in dual mode.
// - After reset every trim is loaded from fuse storage rather than a constant.
// - Holds a twelve-bit single mode first-input offset for the A core with four reserved upper bits.
// - Software can read back every trim and overwrite it with an adjusted value.
module core_trim_register_bank (
  input  wire logic                          clk,            // 200 MHz system clock
  input  wire logic                          rst,            // Synchronous reset, active high
  input  wire logic [trim_pkg::ADDR_W-1:0]   addr,           // Register address
  input  wire logic [trim_pkg::DATA_W-1:0]   wdata,          // Write data
  input  wire logic                          wr,             // Write strobe
  input  wire logic                          rd,             // Read strobe
  output      logic [trim_pkg::DATA_W-1:0]   rdata,          // Read data, cycle after rd
  output      logic [trim_pkg::IDX_W-1:0]    fuse_addr,      // Fuse storage address
  input  wire logic [trim_pkg::DATA_W-1:0]   fuse_data,      // Fuse storage data
  output      logic [trim_pkg::TIMING_W-1:0] a_timing_trim,  // Timing trim to A core
  output      logic [trim_pkg::TIMING_W-1:0] b_timing_trim,  // Timing trim to B core
  output      logic [trim_pkg::OFFSET_W-1:0] a_offset_trim,  // Offset trim to A core
  output      logic                          a_offset_apply, // A offset trim is valid
  output      logic                          trim_apply,     // Timing trims are valid
  output      logic                          loading         // Fuse copy in progress
);
  import trim_pkg::*;

  typedef struct packed {
    logic [TRIM_COUNT-1:0][DATA_W-1:0] trim;
    logic [CTRL_W-1:0]                 ctrl;
    logic [DATA_W-1:0]                 rdata;
  } bank_state_type;

  bank_state_type      cur;
  bank_state_type      next_cur;
  logic                load_we;
  logic [IDX_W-1:0]    load_idx;
  logic [DATA_W-1:0]   load_data;
  logic [IDX_W:0]      hit;
  logic                hit_ok;
  logic [IDX_W-1:0]    hit_idx;

  fuse_loader u_loader (
    .clk       (clk),
    .rst       (rst),
    .fuse_addr (fuse_addr),
    .fuse_data (fuse_data),
    .load_we   (load_we),
    .load_idx  (load_idx),
    .load_data (load_data),
    .loading   (loading)
  );

  always_comb
  begin
    hit      = trim_lookup(addr);
    hit_ok   = hit[IDX_W];
    hit_idx  = hit[IDX_W-1:0];
    next_cur = cur;
    next_cur.rdata = '0;
    if (load_we)
      next_cur.trim[load_idx] = load_data & trim_mask(load_idx);
    else if (wr && hit_ok && !loading)
      next_cur.trim[hit_idx] = wdata & trim_mask(hit_idx);
    if (wr && addr == CTRL_OFS)
      next_cur.ctrl = wdata[CTRL_W-1:0];
    if (rd)
    begin
      if (hit_ok)
        next_cur.rdata = cur.trim[hit_idx];
      else if (addr == CTRL_OFS)
        next_cur.rdata = {13'h0000, cur.ctrl};
      else if (addr == STATUS_OFS)
        next_cur.rdata = {15'h0000, loading};
    end
    if (rst)
    begin
      next_cur.trim  = {TRIM_COUNT{TRIM_RESET}};
      next_cur.ctrl  = CTRL_RESET;
      next_cur.rdata = '0;
    end
  end

  always_ff @(posedge clk)
    cur <= next_cur;

  assign rdata = cur.rdata;

  trim_route u_route (
    .clk            (clk),
    .rst            (rst),
    .trim           (cur.trim),
    .ctrl           (cur.ctrl),
    .a_timing_trim  (a_timing_trim),
    .b_timing_trim  (b_timing_trim),
    .a_offset_trim  (a_offset_trim),
    .a_offset_apply (a_offset_apply),
    .trim_apply     (trim_apply)
  );

  // Mode decode used by the checks below
  logic fg_on;
  logic dual_ina;
  logic dual_inb;
  logic sgl_ina;
  logic sgl_inb;

  assign fg_on    = cur.ctrl[CTRL_FGCAL_BIT];
  assign dual_ina = fg_on && !cur.ctrl[CTRL_SINGLE_BIT] && !cur.ctrl[CTRL_INSEL_BIT];
  assign dual_inb = fg_on && !cur.ctrl[CTRL_SINGLE_BIT] && cur.ctrl[CTRL_INSEL_BIT];
  assign sgl_ina  = fg_on && cur.ctrl[CTRL_SINGLE_BIT] && !cur.ctrl[CTRL_INSEL_BIT];
  assign sgl_inb  = fg_on && cur.ctrl[CTRL_SINGLE_BIT] && cur.ctrl[CTRL_INSEL_BIT];

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  sequence trim_write(logic [ADDR_W-1:0] ofs);
    wr && addr == ofs && !loading;
  endsequence

  sequence write_then_read(logic [ADDR_W-1:0] ofs);
    trim_write(ofs) ##1 (rd && addr == ofs);
  endsequence

  b_dual_store_a: assert property (
    trim_write(B_DUAL_TIMING_OFS) |=> cur.trim[B_DUAL_TIMING_IDX] == ($past(wdata) & TIMING_MASK))
    else $error("b dual timing trim not stored");

  b_dual_route_a: assert property (
    (dual_ina || dual_inb) |=> b_timing_trim == $past(cur.trim[B_DUAL_TIMING_IDX][TIMING_W-1:0]))
    else $error("b dual timing trim not routed");

  a_sgl_ina_a: assert property (
    sgl_ina |=> a_timing_trim == $past(cur.trim[A_SGL_INA_TIM_IDX][TIMING_W-1:0]) && trim_apply)
    else $error("a single first input timing wrong");

  b_sgl_ina_a: assert property (
    sgl_ina |=> b_timing_trim == $past(cur.trim[B_SGL_INA_TIM_IDX][TIMING_W-1:0]))
    else $error("b single first input timing wrong");

  a_sgl_inb_a: assert property (
    sgl_inb |=> a_timing_trim == $past(cur.trim[A_SGL_INB_TIM_IDX][TIMING_W-1:0]) && !a_offset_apply)
    else $error("a single second input timing wrong");

  b_sgl_inb_a: assert property (
    sgl_inb |=> b_timing_trim == $past(cur.trim[B_SGL_INB_TIM_IDX][TIMING_W-1:0]))
    else $error("b single second input timing wrong");

  a_dual_ina_off_a: assert property (
    dual_ina |=> a_offset_apply && a_offset_trim == $past(cur.trim[A_DUAL_INA_OFF_IDX][OFFSET_W-1:0]))
    else $error("a dual first input offset wrong");

  a_dual_inb_off_a: assert property (
    dual_inb |=> a_offset_apply && a_offset_trim == $past(cur.trim[A_DUAL_INB_OFF_IDX][OFFSET_W-1:0]))
    else $error("a dual second input offset wrong");

  fuse_done_a: assert property (
    $fell(loading) |-> $past(load_we) && $past(load_idx) == IDX_W'(TRIM_COUNT - 1))
    else $error("fuse copy ended early");

  fuse_store_a: assert property (
    load_we |=> cur.trim[$past(load_idx)] == ($past(load_data) & trim_mask($past(load_idx))))
    else $error("fuse value not loaded");

  fuse_bound_a: assert property (
    $fell(rst) |-> loading ##10 !loading)
    else $error("fuse copy too long");

  a_sgl_ina_off_a: assert property (
    sgl_ina |=> a_offset_apply && a_offset_trim == $past(cur.trim[A_SGL_INA_OFF_IDX][OFFSET_W-1:0]))
    else $error("a single first input offset wrong");

  timing_back_a: assert property (
    write_then_read(A_SGL_INA_TIM_OFS) |=> rdata == ($past(wdata, 2) & TIMING_MASK))
    else $error("timing trim readback wrong");

  offset_back_a: assert property (
    write_then_read(A_SGL_INA_OFF_OFS) |=> rdata == $past(wdata, 2))
    else $error("offset trim readback wrong");

  read_idle_a: assert property (
    !rd |=> rdata == 16'h0000)
    else $error("read data outside its cycle");

  fg_off_a: assert property (
    !fg_on |=> !trim_apply && !a_offset_apply && a_timing_trim == 8'h00 && b_timing_trim == 8'h00)
    else $error("trims applied with calibration off");

  a_dual_route_a: assert property (
    (dual_ina || dual_inb) |=> a_timing_trim == $past(cur.trim[A_DUAL_TIMING_IDX][TIMING_W-1:0]))
    else $error("a dual timing trim not routed");

  a_dual_store_a: assert property (
    trim_write(A_DUAL_TIMING_OFS) |=> cur.trim[A_DUAL_TIMING_IDX] == ($past(wdata) & TIMING_MASK))
    else $error("a dual timing trim not stored");

  ina_a_store_a: assert property (
    trim_write(A_SGL_INA_TIM_OFS) |=> cur.trim[A_SGL_INA_TIM_IDX] == ($past(wdata) & TIMING_MASK))
    else $error("a single first input timing not stored");

  ina_b_store_a: assert property (
    trim_write(B_SGL_INA_TIM_OFS) |=> cur.trim[B_SGL_INA_TIM_IDX] == ($past(wdata) & TIMING_MASK))
    else $error("b single first input timing not stored");

  inb_a_store_a: assert property (
    trim_write(A_SGL_INB_TIM_OFS) |=> cur.trim[A_SGL_INB_TIM_IDX] == ($past(wdata) & TIMING_MASK))
    else $error("a single second input timing not stored");

  inb_b_store_a: assert property (
    trim_write(B_SGL_INB_TIM_OFS) |=> cur.trim[B_SGL_INB_TIM_IDX] == ($past(wdata) & TIMING_MASK))
    else $error("b single second input timing not stored");

  dual_ina_store_a: assert property (
    trim_write(A_DUAL_INA_OFF_OFS) |=> cur.trim[A_DUAL_INA_OFF_IDX] == ($past(wdata) & OFFSET_MASK))
    else $error("a dual first input offset not stored");

  dual_inb_store_a: assert property (
    trim_write(A_DUAL_INB_OFF_OFS) |=> cur.trim[A_DUAL_INB_OFF_IDX] == ($past(wdata) & OFFSET_MASK))
    else $error("a dual second input offset not stored");

  sgl_off_store_a: assert property (
    trim_write(A_SGL_INA_OFF_OFS) |=> cur.trim[A_SGL_INA_OFF_IDX] == ($past(wdata) & OFFSET_MASK))
    else $error("a single first input offset not stored");

  b_dual_back_a: assert property (
    write_then_read(B_DUAL_TIMING_OFS) |=> rdata == ($past(wdata, 2) & TIMING_MASK))
    else $error("b dual timing readback wrong");

  inb_b_back_a: assert property (
    write_then_read(B_SGL_INB_TIM_OFS) |=> rdata == ($past(wdata, 2) & TIMING_MASK))
    else $error("b single second input readback wrong");

  dual_ina_back_a: assert property (
    write_then_read(A_DUAL_INA_OFF_OFS) |=> rdata == $past(wdata, 2))
    else $error("a dual first input offset readback wrong");

  dual_inb_back_a: assert property (
    write_then_read(A_DUAL_INB_OFF_OFS) |=> rdata == $past(wdata, 2))
    else $error("a dual second input offset readback wrong");

  timing_width_a: assert property (
    (cur.trim[A_DUAL_TIMING_IDX][15:8] | cur.trim[B_DUAL_TIMING_IDX][15:8] | cur.trim[A_SGL_INA_TIM_IDX][15:8]
      | cur.trim[B_SGL_INA_TIM_IDX][15:8] | cur.trim[A_SGL_INB_TIM_IDX][15:8]
      | cur.trim[B_SGL_INB_TIM_IDX][15:8]) == 8'h00)
    else $error("timing trim upper bits set");

  ctrl_store_a: assert property (
    wr && addr == CTRL_OFS |=> cur.ctrl == $past(wdata[CTRL_W-1:0]))
    else $error("mode control not stored");

  ctrl_read_a: assert property (
    rd && addr == CTRL_OFS |=> rdata == {13'h0000, $past(cur.ctrl)})
    else $error("mode control readback wrong");

  status_read_a: assert property (
    rd && addr == STATUS_OFS |=> rdata == {15'h0000, $past(loading)})
    else $error("status readback wrong");

  unmapped_read_a: assert property (
    rd && !hit_ok && addr != CTRL_OFS && addr != STATUS_OFS |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  load_block_a: assert property (
    wr && hit_ok && loading && load_idx != hit_idx |=> cur.trim[$past(hit_idx)] == $past(cur.trim[hit_idx]))
    else $error("trim written during fuse copy");

  load_order_a: assert property (
    load_we && $past(load_we) |-> load_idx == $past(load_idx) + 4'h1)
    else $error("fuse copy out of order");

  load_first_a: assert property (
    $rose(load_we) |-> load_idx == 4'h0)
    else $error("fuse copy did not start at first trim");

  fuse_hold_a: assert property (
    !loading |-> fuse_addr == IDX_W'(TRIM_COUNT - 1))
    else $error("fuse address moved after copy");

  inb_off_zero_a: assert property (
    sgl_inb |=> a_offset_trim == 12'h000)
    else $error("offset routed on single second input");

endmodule

/* File: core_trim_register_bank_tb.sv */
`timescale 1ns/10ps
module core_trim_register_bank_tb;
  import trim_pkg::*;

  logic                  clk;
  logic                  rst;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wdata;
  logic                  wr;
  logic                  rd;
  logic [DATA_W-1:0]     rdata;
  logic [IDX_W-1:0]      fuse_addr;
  logic [DATA_W-1:0]     fuse_data;
  logic [TIMING_W-1:0]   a_timing_trim;
  logic [TIMING_W-1:0]   b_timing_trim;
  logic [OFFSET_W-1:0]   a_offset_trim;
  logic                  a_offset_apply;
  logic                  trim_apply;
  logic                  loading;
  int                    n_errors;
  int                    check_count;
  logic [ADDR_W-1:0]     ofs [TRIM_COUNT];
  logic [DATA_W-1:0]     wv [TRIM_COUNT];
  logic [CTRL_W-1:0]     modes [6];
  logic [DATA_W-1:0]     rd_val;

  core_trim_register_bank dut_u (
    .clk            (clk),
    .rst            (rst),
    .addr           (addr),
    .wdata          (wdata),
    .wr             (wr),
    .rd             (rd),
    .rdata          (rdata),
    .fuse_addr      (fuse_addr),
    .fuse_data      (fuse_data),
    .a_timing_trim  (a_timing_trim),
    .b_timing_trim  (b_timing_trim),
    .a_offset_trim  (a_offset_trim),
    .a_offset_apply (a_offset_apply),
    .trim_apply     (trim_apply),
    .loading        (loading)
  );

  always #2.5 clk = ~clk;

  function automatic logic [DATA_W-1:0] fuse_word(input logic [IDX_W-1:0] k);
    return 16'hA0F0 + 16'h0123 * {12'h000, k};
  endfunction

  function automatic logic [DATA_W-1:0] mask_of(input int k);
    return (k < 6) ? 16'h00FF : 16'hFFFF;
  endfunction

  // Expected core outputs packed as {a timing, b timing, a offset, offset valid, timing valid}
  function automatic logic [31:0] route_expect(input logic [CTRL_W-1:0] m);
    case (m)
      3'b010: return {2'b00, wv[0][7:0], wv[1][7:0], wv[6][11:0], 2'b11};
      3'b110: return {2'b00, wv[0][7:0], wv[1][7:0], wv[7][11:0], 2'b11};
      3'b011: return {2'b00, wv[2][7:0], wv[3][7:0], wv[8][11:0], 2'b11};
      3'b111: return {2'b00, wv[4][7:0], wv[5][7:0], 12'h000, 2'b01};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Fuse storage with one cycle of read latency
  always @(posedge clk) fuse_data <= fuse_word(fuse_addr);

  task automatic results();
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_loaded();
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (loading === 1'b0)
        break;
    end
    if (i == 40)
    begin
      n_errors++;
      $display("MISMATCH t=%0t fuse copy never finished", $time);
      results();
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic check_route(input logic [CTRL_W-1:0] m);
    check({2'b00, a_timing_trim, b_timing_trim, a_offset_trim, a_offset_apply, trim_apply}, route_expect(m));
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    n_errors = 0;
    check_count = 0;
    ofs = '{A_DUAL_TIMING_OFS, B_DUAL_TIMING_OFS, A_SGL_INA_TIM_OFS, B_SGL_INA_TIM_OFS, A_SGL_INB_TIM_OFS,
            B_SGL_INB_TIM_OFS, A_DUAL_INA_OFF_OFS, A_DUAL_INB_OFF_OFS, A_SGL_INA_OFF_OFS};
    modes = '{3'b000, 3'b010, 3'b110, 3'b011, 3'b111, 3'b001};
    do_reset(15);
    wait_loaded();
    check({28'h0, fuse_addr}, {28'h0, IDX_W'(TRIM_COUNT - 1)});
    for (int k = 0; k < TRIM_COUNT; k++)
    begin
      bus_read(ofs[k], rd_val);
      check({16'h0, rd_val}, {16'h0, fuse_word(IDX_W'(k)) & mask_of(k)});
      wv[k] = 16'h0F0F ^ 16'(16'h1111 * k);
    end
    bus_read(STATUS_OFS, rd_val);
    check({16'h0, rd_val}, 32'h0);
    bus_read(CTRL_OFS, rd_val);
    check({16'h0, rd_val}, 32'h0);
    check_route(3'b000);
    // All ones shows the kept width of each trim, reserved offset bits included
    for (int k = 0; k < TRIM_COUNT; k++)
    begin
      bus_write(ofs[k], 16'hFFFF);
      bus_read(ofs[k], rd_val);
      check({16'h0, rd_val}, {16'h0, mask_of(k)});
    end
    // Write then read on the next cycle, and read data stand one cycle only
    for (int k = 0; k < TRIM_COUNT; k++)
    begin
      @(posedge clk);
      addr  <= ofs[k];
      wdata <= wv[k];
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check({16'h0, rdata}, {16'h0, wv[k] & mask_of(k)});
      @(posedge clk);
      #1;
      check({16'h0, rdata}, 32'h0);
    end
    bus_write(12'h311, 16'h00AA);
    bus_read(12'h311, rd_val);
    check({16'h0, rd_val}, 32'h0);
    bus_read(A_DUAL_TIMING_OFS, rd_val);
    check({16'h0, rd_val}, {24'h0, wv[0][7:0]});
    bus_write(STATUS_OFS, 16'hFFFF);
    bus_read(STATUS_OFS, rd_val);
    check({16'h0, rd_val}, 32'h0);
    // Every mode, core and input combination with calibration on, and calibration off in both modes on the first input
    for (int i = 0; i < 6; i++)
    begin
      bus_write(CTRL_OFS, {13'h0000, modes[i]});
      @(posedge clk);
      @(posedge clk);
      #1;
      check_route(modes[i]);
      bus_read(CTRL_OFS, rd_val);
      check({16'h0, rd_val}, {29'h0, modes[i]});
    end
    // A trim rewritten while its route is live reaches the core
    bus_write(CTRL_OFS, 16'h0007);
    bus_write(A_SGL_INB_TIM_OFS, 16'h0042);
    wv[4] = 16'h0042;
    @(posedge clk);
    #1;
    check_route(3'b111);
    // Second reset: a write to a trim already loaded, still inside the fuse copy, is dropped
    do_reset(2);
    repeat (3) @(posedge clk);
    bus_write(A_DUAL_TIMING_OFS, 16'h0055);
    wait_loaded();
    bus_read(A_DUAL_TIMING_OFS, rd_val);
    check({16'h0, rd_val}, {16'h0, fuse_word(4'h0) & 16'h00FF});
    bus_read(A_SGL_INA_OFF_OFS, rd_val);
    check({16'h0, rd_val}, {16'h0, fuse_word(4'h8)});
    bus_read(A_SGL_INB_TIM_OFS, rd_val);
    check({16'h0, rd_val}, {16'h0, fuse_word(4'h4) & 16'h00FF});
    bus_read(CTRL_OFS, rd_val);
    check({16'h0, rd_val}, 32'h0);
    check_route(3'b000);
    results();
  end

  initial
  begin
    #200000;
    n_errors++;
    $display("MISMATCH t=%0t run did not complete", $time);
    results();
  end
endmodule
